// *** rtl/lcd_device_end.sv ***
`timescale 1ns/100ps
module lcd_device_end (
    // Clock and reset; the clock stands in for the oscillator input.
    input wire logic ref_clk,
    input wire logic rst,
    // Host bus
    lcd_bus_if.device bus,
    // Configuration
    input wire logic four_bit_mode,
    input wire lcd_port_pkg::duty_t duty_sel,
    // Accepted instruction
    output logic [7:0] instruction_code,
    output logic instruction_valid,
    // Display drive
    output logic [15:0] common_drive_lines,
    output logic [39:0] segment_drive_lines,
    // Extension driver link
    output logic pattern_latch_clock,
    output logic pattern_shift_clock,
    output logic pattern_data,
    output logic alternation_signal
);
    import lcd_port_pkg::*;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_STROBE = 1'b1
    } bus_state_t;

    logic [7:0] display_ram [RAM_WORDS];

    ////////////////////////////////////////////////////////////////////////////
    bus_state_t bus_state_reg, bus_state_next;
    logic nibble_reg, nibble_next;
    logic [3:0] rx_high_reg, rx_high_next;
    logic [7:0] read_byte_reg, read_byte_next;
    logic [7:0] instruction_reg, instruction_next;
    logic instr_valid_reg, instr_valid_next;
    logic [7:0] transfer_data_reg, transfer_data_next;
    logic [6:0] ram_address_counter_reg, ram_address_counter_next;
    logic [8:0] busy_count_reg, busy_count_next;
    logic busy_flag;
    logic [7:0] byte_in;
    logic drive;
    logic ram_we;
    logic [6:0] ram_waddr;
    logic [7:0] ram_wdata;

    assign busy_flag = (busy_count_reg != 9'h000);

    always_comb begin
        bus_state_next = bus_state_reg;
        nibble_next = nibble_reg;
        rx_high_next = rx_high_reg;
        read_byte_next = read_byte_reg;
        instruction_next = instruction_reg;
        instr_valid_next = 1'b0;
        transfer_data_next = transfer_data_reg;
        ram_address_counter_next = ram_address_counter_reg;
        busy_count_next = busy_flag ? busy_count_reg - 9'h001 : busy_count_reg;
        ram_we = 1'b0;
        ram_waddr = ram_address_counter_reg;
        ram_wdata = RESET_BYTE;
        byte_in = four_bit_mode ? {rx_high_reg, bus.high_data_lines}
                                : {bus.high_data_lines, bus.low_data_lines};
        case (bus_state_reg)
            BUS_IDLE: begin
                if (bus.enable_strobe) begin
                    bus_state_next = BUS_STROBE;
                    // The status is frozen at the first nibble so both halves agree.
                    if (bus.read_select && !nibble_reg) begin
                        read_byte_next = bus.register_select ? transfer_data_reg
                            : {busy_flag, ram_address_counter_reg};
                    end
                end
            end
            BUS_STROBE: begin
                if (!bus.enable_strobe) begin
                    bus_state_next = BUS_IDLE;
                    if (four_bit_mode && !nibble_reg) begin
                        nibble_next = 1'b1;
                        rx_high_next = bus.high_data_lines;
                    end else begin
                        nibble_next = 1'b0;
                        if (bus.read_select) begin
                            if (bus.register_select) begin
                                ram_address_counter_next = ram_address_counter_reg + 7'h01;
                                transfer_data_next = display_ram[ram_address_counter_reg + 7'h01];
                            end
                        end else if (!busy_flag) begin
                            busy_count_next = 9'(BUSY_CYCLES);
                            if (!bus.register_select) begin
                                instruction_next = byte_in;
                                instr_valid_next = 1'b1;
                                if (byte_in == INSTR_CLEAR) begin
                                    ram_address_counter_next = RESET_ADDR;
                                end else if (byte_in[SET_ADDR_BIT]) begin
                                    ram_address_counter_next = byte_in[6:0];
                                    transfer_data_next = display_ram[byte_in[6:0]];
                                end
                            end else begin
                                ram_we = 1'b1;
                                ram_wdata = byte_in;
                                ram_address_counter_next = ram_address_counter_reg + 7'h01;
                            end
                        end
                    end
                end
            end
            default: bus_state_next = BUS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_state_reg <= BUS_IDLE;
            nibble_reg <= 1'b0;
            rx_high_reg <= 4'h0;
            read_byte_reg <= RESET_BYTE;
            instruction_reg <= RESET_BYTE;
            instr_valid_reg <= 1'b0;
            transfer_data_reg <= RESET_BYTE;
            ram_address_counter_reg <= RESET_ADDR;
            busy_count_reg <= 9'h000;
        end else begin
            bus_state_reg <= bus_state_next;
            nibble_reg <= nibble_next;
            rx_high_reg <= rx_high_next;
            read_byte_reg <= read_byte_next;
            instruction_reg <= instruction_next;
            instr_valid_reg <= instr_valid_next;
            transfer_data_reg <= transfer_data_next;
            ram_address_counter_reg <= ram_address_counter_next;
            busy_count_reg <= busy_count_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ram_we) begin
            display_ram[ram_waddr] <= ram_wdata;
        end
    end

    // Drive only while the strobe is still high, so the host never meets
    // the device on the lines after the strobe falls.
    assign drive = (bus_state_reg == BUS_STROBE) && bus.enable_strobe
        && bus.read_select;
    assign bus.dev_data_oe = {drive, drive && !four_bit_mode};
    assign bus.dev_data_out = !four_bit_mode ? read_byte_reg
        : (nibble_reg ? {read_byte_reg[3:0], 4'h0} : {read_byte_reg[7:4], 4'h0});
    assign instruction_code = instruction_reg;
    assign instruction_valid = instr_valid_reg;

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] phase_reg, phase_next;
    logic [3:0] row_reg, row_next;
    logic [2:0] dot_col_reg, dot_col_next;
    logic [2:0] dot_char_reg, dot_char_next;
    logic alt_reg, alt_next;
    logic shift_reg, shift_next;
    logic latch_reg, latch_next;
    logic serial_reg, serial_next;
    logic [15:0] common_reg, common_next;
    logic [39:0] segment_reg, segment_next;
    logic [3:0] last_row;
    logic [6:0] line_base;
    logic [7:0] ext_byte;

    always_comb begin
        case (duty_sel)
            DUTY_8: last_row = 4'h7;
            DUTY_11: last_row = 4'ha;
            default: last_row = 4'hf;
        endcase
        line_base = (row_reg[3] && duty_sel == DUTY_16) ? LINE2_BASE : RESET_ADDR;
        ext_byte = display_ram[line_base + EXT_CHAR_BASE + {4'h0, dot_char_reg}];
        phase_next = phase_reg + 8'h01;
        row_next = row_reg;
        dot_col_next = dot_col_reg;
        dot_char_next = dot_char_reg;
        alt_next = alt_reg;
        serial_next = serial_reg;
        segment_next = segment_reg;
        shift_next = 1'b0;
        latch_next = 1'b0;
        if (phase_reg < SHIFT_PHASES) begin
            if (!phase_reg[0]) begin
                serial_next = ext_byte[dot_col_reg];
            end else begin
                shift_next = 1'b1;
                if (dot_col_reg == 3'(DOTS_PER_CHAR - 1)) begin
                    dot_col_next = 3'h0;
                    dot_char_next = dot_char_reg + 3'h1;
                end else begin
                    dot_col_next = dot_col_reg + 3'h1;
                end
            end
        end else if (phase_reg == SHIFT_PHASES) begin
            latch_next = 1'b1;
            for (int c = 0; c < CHARS_PER_SIDE; c++) begin
                for (int d = 0; d < DOTS_PER_CHAR; d++) begin
                    segment_next[c * DOTS_PER_CHAR + d] = display_ram[line_base + 7'(c)][d];
                end
            end
        end
        if (phase_reg == LAST_PHASE) begin
            phase_next = 8'h00;
            dot_col_next = 3'h0;
            dot_char_next = 3'h0;
            if (row_reg >= last_row) begin
                row_next = 4'h0;
                alt_next = !alt_reg;
            end else begin
                row_next = row_reg + 4'h1;
            end
        end
        // Rows past the duty never select, so their commons stay non-selected.
        common_next = 16'h0000;
        if (row_next <= last_row) begin
            common_next[row_next] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_reg <= 8'h00;
            row_reg <= 4'h0;
            dot_col_reg <= 3'h0;
            dot_char_reg <= 3'h0;
            alt_reg <= 1'b0;
            shift_reg <= 1'b0;
            latch_reg <= 1'b0;
            serial_reg <= 1'b0;
            common_reg <= 16'h0000;
            segment_reg <= 40'h0000000000;
        end else begin
            phase_reg <= phase_next;
            row_reg <= row_next;
            dot_col_reg <= dot_col_next;
            dot_char_reg <= dot_char_next;
            alt_reg <= alt_next;
            shift_reg <= shift_next;
            latch_reg <= latch_next;
            serial_reg <= serial_next;
            common_reg <= common_next;
            segment_reg <= segment_next;
        end
    end

    assign common_drive_lines = common_reg;
    assign segment_drive_lines = segment_reg;
    assign pattern_latch_clock = latch_reg;
    assign pattern_shift_clock = shift_reg;
    assign pattern_data = serial_reg;
    assign alternation_signal = alt_reg;
endmodule

// *** rtl/lcd_port_pkg.sv ***
// Behaviour
// - Register select low on write: instruction register.
// - Register select low on read: busy and address.
// - Register select high: data register, both directions.
// - Read select 0 writes, 1 reads; strobe starts.
// - High data lines bidirectional; top line shows busy.
// - Four-bit mode leaves low data lines unused.
// - Latch clock latches shifted pattern data.
// - Shift clock advances serial pattern data.
// - Serial data carries each extension segment dot.
// - Alternation signal flips drive polarity for AC.
// - Unused commons carry non-selection for duty.
// - External clock enters the oscillator input only.
// - Busy ignores instructions; host polls until clear.
// - Status read: counter low seven, busy top.
package lcd_port_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int SETUP_TIME_NS = 40;
    localparam int PULSE_TIME_NS = 230;
    localparam int HOLD_TIME_NS = 10;
    localparam int BUSY_TIME_NS = 37000;
    localparam int ROW_TIME_NS = 25000;
    localparam int SETUP_CYCLES = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_CYCLES = ROW_TIME_NS / CLK_PERIOD_NS;

    localparam int BUSY_BIT = 7;
    localparam int SET_ADDR_BIT = 7;
    localparam logic [7:0] INSTR_CLEAR = 8'h01;
    localparam logic [6:0] LINE2_BASE = 7'h40;
    localparam logic [6:0] EXT_CHAR_BASE = 7'h08;
    localparam int RAM_WORDS = 128;
    localparam int COM_LINES = 16;
    localparam int SEG_LINES = 40;
    localparam int DOTS_PER_CHAR = 5;
    localparam int CHARS_PER_SIDE = 8;
    localparam logic [7:0] SHIFT_PHASES = 8'h50;
    localparam logic [7:0] LAST_PHASE = 8'(ROW_CYCLES - 1);
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [6:0] RESET_ADDR = 7'h00;

    typedef enum logic [1:0] {
        DUTY_8 = 2'h0,
        DUTY_11 = 2'h1,
        DUTY_16 = 2'h2
    } duty_t;

endpackage

// *** rtl/lcd_bus_if.sv ***
`timescale 1ns/100ps
interface lcd_bus_if;
    logic register_select;
    logic read_select;
    logic enable_strobe;
    logic [7:0] host_data_out;
    logic [1:0] host_data_oe;
    logic [7:0] dev_data_out;
    logic [1:0] dev_data_oe;
    logic [3:0] high_data_lines;
    logic [3:0] low_data_lines;

    // Undriven lines float high, as with bus pull-ups.
    always_comb begin
        high_data_lines = dev_data_oe[1] ? dev_data_out[7:4] :
            (host_data_oe[1] ? host_data_out[7:4] : 4'hf);
        low_data_lines = dev_data_oe[0] ? dev_data_out[3:0] :
            (host_data_oe[0] ? host_data_out[3:0] : 4'hf);
    end

    modport device (
        input register_select,
        input read_select,
        input enable_strobe,
        input high_data_lines,
        input low_data_lines,
        output dev_data_out,
        output dev_data_oe
    );

    modport host (
        output register_select,
        output read_select,
        output enable_strobe,
        output host_data_out,
        output host_data_oe,
        input high_data_lines,
        input low_data_lines
    );
endinterface

// *** rtl/lcd_host_end.sv ***
`timescale 1ns/100ps
module lcd_host_end (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Device bus
    lcd_bus_if.host bus,
    // Configuration
    input wire logic four_bit_mode,
    // Command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_register_select,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_data,
    // Response port
    output logic resp_valid,
    output logic [7:0] resp_data
);
    import lcd_port_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SETUP = 2'b01,
        H_PULSE = 2'b11,
        H_HOLD = 2'b10
    } host_state_t;

    host_state_t state_reg, state_next;
    logic [1:0] count_reg, count_next;
    logic polling_reg, polling_next;
    logic nibble_reg, nibble_next;
    logic target_reg, target_next;
    logic read_reg, read_next;
    logic [7:0] byte_reg, byte_next;
    logic [7:0] rx_reg, rx_next;
    logic resp_valid_reg, resp_valid_next;
    logic [7:0] resp_data_reg, resp_data_next;
    logic bus_read;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        polling_next = polling_reg;
        nibble_next = nibble_reg;
        target_next = target_reg;
        read_next = read_reg;
        byte_next = byte_reg;
        rx_next = rx_reg;
        resp_valid_next = 1'b0;
        resp_data_next = resp_data_reg;
        case (state_reg)
            H_IDLE: begin
                if (cmd_valid) begin
                    target_next = cmd_register_select;
                    read_next = cmd_read;
                    byte_next = cmd_data;
                    // Every write waits behind a status poll.
                    polling_next = !cmd_read;
                    nibble_next = 1'b0;
                    count_next = 2'(SETUP_CYCLES - 1);
                    state_next = H_SETUP;
                end
            end
            H_SETUP: begin
                if (count_reg == 2'h0) begin
                    count_next = 2'(PULSE_CYCLES - 1);
                    state_next = H_PULSE;
                end else begin
                    count_next = count_reg - 2'h1;
                end
            end
            H_PULSE: begin
                if (count_reg == 2'h0) begin
                    if (!four_bit_mode) begin
                        rx_next = {bus.high_data_lines, bus.low_data_lines};
                    end else if (!nibble_reg) begin
                        rx_next[7:4] = bus.high_data_lines;
                    end else begin
                        rx_next[3:0] = bus.high_data_lines;
                    end
                    count_next = 2'(HOLD_CYCLES - 1);
                    state_next = H_HOLD;
                end else begin
                    count_next = count_reg - 2'h1;
                end
            end
            H_HOLD: begin
                if (count_reg != 2'h0) begin
                    count_next = count_reg - 2'h1;
                end else if (four_bit_mode && !nibble_reg) begin
                    nibble_next = 1'b1;
                    count_next = 2'(SETUP_CYCLES - 1);
                    state_next = H_SETUP;
                end else begin
                    nibble_next = 1'b0;
                    count_next = 2'(SETUP_CYCLES - 1);
                    if (polling_reg) begin
                        polling_next = rx_reg[BUSY_BIT];
                        state_next = H_SETUP;
                    end else begin
                        resp_valid_next = read_reg;
                        resp_data_next = rx_reg;
                        state_next = H_IDLE;
                    end
                end
            end
            default: state_next = H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= H_IDLE;
            count_reg <= 2'h0;
            polling_reg <= 1'b0;
            nibble_reg <= 1'b0;
            target_reg <= 1'b0;
            read_reg <= 1'b0;
            byte_reg <= RESET_BYTE;
            rx_reg <= RESET_BYTE;
            resp_valid_reg <= 1'b0;
            resp_data_reg <= RESET_BYTE;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            polling_reg <= polling_next;
            nibble_reg <= nibble_next;
            target_reg <= target_next;
            read_reg <= read_next;
            byte_reg <= byte_next;
            rx_reg <= rx_next;
            resp_valid_reg <= resp_valid_next;
            resp_data_reg <= resp_data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign bus_read = polling_reg || read_reg;
    assign bus.register_select = !polling_reg && target_reg;
    assign bus.read_select = bus_read;
    assign bus.enable_strobe = (state_reg == H_PULSE);
    assign bus.host_data_oe = (state_reg != H_IDLE && !bus_read) ?
        {1'b1, !four_bit_mode} : 2'b00;
    assign bus.host_data_out = !four_bit_mode ? byte_reg
        : (nibble_reg ? {byte_reg[3:0], 4'h0} : {byte_reg[7:4], 4'h0});
    assign cmd_ready = (state_reg == H_IDLE);
    assign resp_valid = resp_valid_reg;
    assign resp_data = resp_data_reg;
endmodule

// *** dv/lcd_port_checker.sv ***
`timescale 1ns/100ps
module lcd_port_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Mode
    input wire logic four_bit_mode,
    // Bus
    input wire logic register_select,
    input wire logic read_select,
    input wire logic enable_strobe,
    input wire logic [1:0] host_data_oe,
    input wire logic [1:0] dev_data_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_dev_read_only: assert property (
        |dev_data_oe |-> enable_strobe && read_select) else $error("device drives off read");
    a_read_answer_prompt: assert property (
        $rose(enable_strobe) && read_select |=> dev_data_oe[1]) else $error("read not answered");
    a_strobe_three_cycles: assert property (
        $rose(enable_strobe) |-> enable_strobe [*3] ##1 !enable_strobe)
        else $error("strobe width wrong");
    a_select_steady: assert property (
        enable_strobe || $past(enable_strobe) |-> $stable(register_select) && $stable(read_select))
        else $error("select moved during transfer");
    a_host_quiet_read: assert property (
        enable_strobe && read_select |-> host_data_oe == 2'h0) else $error("host drives on read");
    a_host_drives_write: assert property (
        enable_strobe && !read_select |-> host_data_oe[1]) else $error("host silent on write");
    a_low_lines_unused: assert property (
        four_bit_mode |-> !host_data_oe[0] && !dev_data_oe[0]) else $error("low lines used");
    a_full_width_write: assert property (
        !four_bit_mode && enable_strobe && !read_select |-> host_data_oe == 2'h3)
        else $error("narrow write");

    c_status_read: cover property ($rose(enable_strobe) && read_select && !register_select);
    c_nibble_write: cover property (four_bit_mode && $rose(enable_strobe) && !read_select);
    c_data_read: cover property (register_select && read_select && dev_data_oe[1]);
endmodule

// *** dv/char_lcd_host_and_drive_pins_tb.sv ***
`timescale 1ns/100ps
module char_lcd_host_and_drive_pins_tb;
    import lcd_port_pkg::*;

    typedef struct packed {
        logic sel;
        logic rd;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;

    logic ref_clk, rst, four_bit_mode, cmd_valid, cmd_ready, cmd_register_select, cmd_read;
    logic resp_valid, instruction_valid, pattern_latch_clock, pattern_shift_clock;
    logic pattern_data, alternation_signal;
    logic [7:0] cmd_data, resp_data, instruction_code, code_b, got, dat;
    logic [15:0] common_drive_lines;
    logic [39:0] segment_drive_lines;
    logic [7:0] dot_byte = 8'h15;
    duty_t duty_sel;
    int mismatches = 0;
    int total_checks = 0;
    row_t rows [7];

    lcd_bus_if bus ();
    lcd_bus_if bus_b ();

    lcd_device_end u_lcd_device_end (.ref_clk(ref_clk), .rst(rst), .bus(bus),
        .four_bit_mode(four_bit_mode), .duty_sel(duty_sel), .instruction_code(instruction_code),
        .instruction_valid(instruction_valid), .common_drive_lines(common_drive_lines),
        .segment_drive_lines(segment_drive_lines), .pattern_latch_clock(pattern_latch_clock),
        .pattern_shift_clock(pattern_shift_clock), .pattern_data(pattern_data),
        .alternation_signal(alternation_signal));
    lcd_host_end u_lcd_host_end (.ref_clk(ref_clk), .rst(rst), .bus(bus),
        .four_bit_mode(four_bit_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_register_select(cmd_register_select), .cmd_read(cmd_read), .cmd_data(cmd_data),
        .resp_valid(resp_valid), .resp_data(resp_data));
    // The bench plays a careless host here, since the real host end polls before every write.
    lcd_device_end u_lcd_device_end_b (.ref_clk(ref_clk), .rst(rst), .bus(bus_b),
        .four_bit_mode(1'b0), .duty_sel(DUTY_8), .instruction_code(code_b),
        .instruction_valid(), .common_drive_lines(), .segment_drive_lines(),
        .pattern_latch_clock(), .pattern_shift_clock(), .pattern_data(),
        .alternation_signal());
    lcd_port_checker u_lcd_port_checker (.ref_clk(ref_clk), .rst(rst),
        .four_bit_mode(four_bit_mode), .register_select(bus.register_select),
        .read_select(bus.read_select), .enable_strobe(bus.enable_strobe),
        .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe));

    always #50 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cmd(input logic sel, input logic rd, input logic [7:0] d, output logic [7:0] q);
        int n;
        cmd_register_select = sel;
        cmd_read = rd;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(posedge ref_clk);
        #10 cmd_valid = 1'b0;
        // Writes may wait out a whole busy period, so the bound is generous.
        for (n = 0; n < 2000; n++) begin
            @(posedge ref_clk);
            #1;
            if ((rd ? resp_valid : cmd_ready) === 1'b1) break;
        end
        q = resp_data;
        if (n == 2000) begin
            mismatches++;
            tally_and_finish();
        end
        #9;
    endtask

    task automatic raw(input logic sel, input logic rd, input logic [7:0] d, output logic [7:0] q);
        // Wait an edge first so the release of the last call never meets the next request.
        @(posedge ref_clk);
        #10 bus_b.register_select = sel;
        bus_b.read_select = rd;
        bus_b.host_data_out = d;
        bus_b.host_data_oe = rd ? 2'h0 : 2'h3;
        @(posedge ref_clk);
        #10 bus_b.enable_strobe = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 q = {bus_b.high_data_lines, bus_b.low_data_lines};
        #9 bus_b.enable_strobe = 1'b0;
        @(posedge ref_clk);
        #10 bus_b.host_data_oe = 2'h0;
    endtask

    task automatic watch(input int cycles, input logic [15:0] com_exp, input int tog_exp);
        int lat = 0;
        int sh = 0;
        int tog = 0;
        int idx = 99;
        logic [15:0] seen = 16'h0000;
        logic alt = alternation_signal;
        repeat (cycles) begin
            @(posedge ref_clk);
            #1;
            seen |= common_drive_lines;
            if (pattern_latch_clock === 1'b1) begin
                lat++;
                idx = 0;
            end
            if (pattern_shift_clock === 1'b1) begin
                sh++;
                if (idx < 5) check("dot", 16'(pattern_data), 16'(dot_byte[idx]));
                idx++;
            end
            tog += int'(alternation_signal !== alt);
            alt = alternation_signal;
        end
        #9;
        check("latches", 16'(lat), 16'(cycles / ROW_CYCLES));
        check("shifts", 16'(sh), 16'(cycles / ROW_CYCLES * 40));
        check("toggles", 16'(tog), 16'(tog_exp));
        check("commons", seen, com_exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        four_bit_mode = 1'b0;
        duty_sel = DUTY_8;
        cmd_valid = 1'b0;
        cmd_register_select = 1'b0;
        cmd_read = 1'b0;
        cmd_data = 8'h00;
        bus_b.register_select = 1'b0;
        bus_b.read_select = 1'b0;
        bus_b.enable_strobe = 1'b0;
        bus_b.host_data_out = 8'h00;
        bus_b.host_data_oe = 2'h0;
        rows = '{'{1'b0, 1'b0, 8'h80, 8'h00}, '{1'b1, 1'b0, 8'ha5, 8'h00},
            '{1'b1, 1'b0, 8'h3c, 8'h00}, '{1'b0, 1'b0, 8'h80, 8'h00},
            '{1'b1, 1'b1, 8'h00, 8'ha5}, '{1'b1, 1'b1, 8'h00, 8'h3c},
            '{1'b0, 1'b1, 8'h00, 8'h82}};
        repeat (16) @(posedge ref_clk);
        #10 rst = 1'b0;
        @(posedge ref_clk);
        #1 got = {3'h0, cmd_ready, bus.dev_data_oe, bus.enable_strobe, instruction_valid};
        check("reset", got, 8'h10);
        #9;
        // Data rows flip in the second pass so stale bytes from the first cannot match.
        for (int m = 0; m < 2; m++) begin
            four_bit_mode = m[0];
            foreach (rows[i]) begin
                dat = rows[i].sel ? {8{m[0]}} : 8'h00;
                cmd(rows[i].sel, rows[i].rd, rows[i].d ^ dat, got);
                if (rows[i].rd) check("read", got, rows[i].e ^ dat);
                else if (!rows[i].sel) check("instr", instruction_code, rows[i].d);
            end
        end
        raw(1'b0, 1'b0, 8'h80, got);
        raw(1'b0, 1'b0, 8'hc5, got);
        raw(1'b0, 1'b1, 8'h00, got);
        check("busy_status", got, 8'h80);
        check("kept_code", code_b, 8'h80);
        cmd(1'b0, 1'b0, 8'h88, got);
        cmd(1'b1, 1'b0, dot_byte, got);
        watch(4000, 16'h00ff, 2);
        check("segments", 16'(segment_drive_lines[9:0]), 16'h007a);
        duty_sel = DUTY_11;
        watch(2750, 16'h07ff, 1);
        watch(5500, 16'h07ff, 2);
        // The second line starts at its own base, so its first extension character needs dots too.
        cmd(1'b0, 1'b0, 8'hc8, got);
        cmd(1'b1, 1'b0, dot_byte, got);
        duty_sel = DUTY_16;
        watch(4000, 16'hffff, 1);
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #10 rst = 1'b0;
        @(posedge ref_clk);
        #1 got = {3'h0, cmd_ready, bus.dev_data_oe, alternation_signal, pattern_latch_clock};
        check("reset_mid", got, 8'h10);
        check("reset_com", common_drive_lines, 16'h0001);
        #9;
        tally_and_finish();
    end
endmodule
